// ==== hw/fcs_defs.svh ====
// Constants for the flash command/status controller.
// Assumes a 20 MHz reference clock; all timing counts derive from it.
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// ----------------------------------------
// Clock and flash bus timing
// ----------------------------------------
`define FCS_CLK_NS 50
`define FCS_T_SETUP_NS 50
`define FCS_T_STROBE_NS 100
`define FCS_T_HOLD_NS 50
// Least times round up to whole cycles
`define FCS_CYC(ns) (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

// ----------------------------------------
// Flash command addresses and codes
// ----------------------------------------
`define FCS_ADDR_UNLOCK1 22'h000555
`define FCS_ADDR_UNLOCK2 22'h0002AA
`define FCS_ADDR_ANY 22'h000000
`define FCS_DATA_UNLOCK1 8'hAA
`define FCS_DATA_UNLOCK2 8'h55
`define FCS_CMD_RESET 8'hF0
`define FCS_CMD_PROGRAM 8'hA0
`define FCS_CMD_ERASE_SETUP 8'h80
`define FCS_CMD_CHIP_ERASE 8'h10
`define FCS_CMD_SECTOR_ERASE 8'h30
`define FCS_CMD_AUTOSELECT 8'h90
`define FCS_CMD_SUSPEND 8'hB0
`define FCS_CMD_RESUME 8'h30

// ----------------------------------------
// Status bit positions on the flash data bus
// ----------------------------------------
`define FCS_TOGGLE_BIT 6
`define FCS_TIMEOUT_BIT 5

// ----------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------
`define FCS_REG_CTRL 4'h0
`define FCS_REG_ADDR 4'h4
`define FCS_REG_DATA 4'h8
`define FCS_REG_STATUS 4'hC
`define FCS_CTRL_OP_LSB 0
`define FCS_CTRL_OP_MSB 3
`define FCS_CTRL_START 4
`define FCS_CTRL_HWRST 8
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_RDY 3
`define FCS_ST_RD_LSB 8
`define FCS_ST_RD_MSB 15
`define FCS_RESP_OKAY 2'h0
`define FCS_RESP_SLVERR 2'h2

`endif

// ==== hw/fcs_pkg.sv ====
// Types shared by the flash command/status controller files.
// Constants live in fcs_defs.svh.
package fcs_pkg;
	typedef enum logic [3:0] {
		FCS_OP_READ = 4'h0,
		FCS_OP_RESET = 4'h1,
		FCS_OP_PROGRAM = 4'h2,
		FCS_OP_CHIP_ERASE = 4'h3,
		FCS_OP_SECTOR_ERASE = 4'h4,
		FCS_OP_ADD_SECTOR = 4'h5,
		FCS_OP_SUSPEND = 4'h6,
		FCS_OP_RESUME = 4'h7,
		FCS_OP_AUTOSELECT = 4'h8
	} fcs_op_t;

	typedef enum logic [5:0] {
		FCS_ST_IDLE = 6'b000001,
		FCS_ST_CMD = 6'b000010,
		FCS_ST_POLL_A = 6'b000100,
		FCS_ST_POLL_B = 6'b001000,
		FCS_ST_POLL_C = 6'b010000,
		FCS_ST_FINAL = 6'b100000
	} fcs_state_t;

	typedef enum logic [3:0] {
		FCS_CY_IDLE = 4'b0001,
		FCS_CY_SETUP = 4'b0010,
		FCS_CY_STROBE = 4'b0100,
		FCS_CY_HOLD = 4'b1000
	} fcs_cyc_t;
endpackage

// ==== hw/fcs_bus_cycle.sv ====
// One flash bus cycle, write or read, with setup, strobe and hold phases.
// Assumes the flash data input is synchronous to the reference clock.
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_bus_cycle (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_read,
	input wire logic [21:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_dq_in,
	output logic o_done,
	output logic [7:0] o_rdata,
	output logic [21:0] o_addr,
	output logic [7:0] o_dq_out,
	output logic o_dq_oe,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n
);
	import fcs_pkg::*;

	localparam logic [3:0] SETUP_LAST = 4'(`FCS_CYC(`FCS_T_SETUP_NS) - 1);
	localparam logic [3:0] STROBE_LAST = 4'(`FCS_CYC(`FCS_T_STROBE_NS) - 1);
	localparam logic [3:0] HOLD_LAST = 4'(`FCS_CYC(`FCS_T_HOLD_NS) - 1);

	fcs_cyc_t state;
	logic [3:0] cnt;
	logic is_read;

	// Address and data settle a full setup phase before the falling edge, so the
	// later of the two falling edges sees a stable address; data is held past the rising edge.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= FCS_CY_IDLE;
			cnt <= 4'h0;
			is_read <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 8'h00;
			o_addr <= 22'h000000;
			o_dq_out <= 8'h00;
			o_dq_oe <= 1'b0;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
		end else if (i_ce) begin
			o_done <= 1'b0;
			cnt <= cnt + 4'h1;
			unique case (state)
				FCS_CY_IDLE: begin
					cnt <= 4'h0;
					if (i_start) begin
						state <= FCS_CY_SETUP;
						is_read <= i_read;
						o_addr <= i_addr;
						o_dq_out <= i_wdata;
						o_dq_oe <= !i_read;
					end
				end
				FCS_CY_SETUP: begin
					if (cnt == SETUP_LAST) begin
						state <= FCS_CY_STROBE;
						cnt <= 4'h0;
						o_ce_n <= 1'b0;
						o_we_n <= is_read;
						o_oe_n <= !is_read;
					end
				end
				FCS_CY_STROBE: begin
					if (cnt == STROBE_LAST) begin
						state <= FCS_CY_HOLD;
						cnt <= 4'h0;
						o_ce_n <= 1'b1;
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						if (is_read) begin
							o_rdata <= i_dq_in;
						end
					end
				end
				FCS_CY_HOLD: begin
					if (cnt == HOLD_LAST) begin
						state <= FCS_CY_IDLE;
						o_dq_oe <= 1'b0;
						o_done <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule

// ==== hw/fcs_ctrl.sv ====
// Host-side controller for a byte-wide parallel flash: issues command sequences,
// polls write status and reports through AXI4-Lite registers.
// Assumes flash pins and AXI signals are synchronous to i_ref_clk.
`timescale 1ns/1ps
`include "fcs_defs.svh"

module fcs_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// AXI4-Lite slave
	input wire logic [3:0] i_s_awaddr,
	input wire logic i_s_awvalid,
	output logic o_s_awready,
	input wire logic [31:0] i_s_wdata,
	input wire logic [3:0] i_s_wstrb,
	input wire logic i_s_wvalid,
	output logic o_s_wready,
	output logic [1:0] o_s_bresp,
	output logic o_s_bvalid,
	input wire logic i_s_bready,
	input wire logic [3:0] i_s_araddr,
	input wire logic i_s_arvalid,
	output logic o_s_arready,
	output logic [31:0] o_s_rdata,
	output logic [1:0] o_s_rresp,
	output logic o_s_rvalid,
	input wire logic i_s_rready,
	// Flash pins
	output logic [21:0] o_fl_addr,
	output logic [7:0] o_fl_dq_out,
	output logic o_fl_dq_oe,
	input wire logic [7:0] i_fl_dq_in,
	output logic o_fl_ce_n,
	output logic o_fl_we_n,
	output logic o_fl_oe_n,
	output logic o_fl_reset_n,
	input wire logic i_fl_ready_busy_n
);
	import fcs_pkg::*;

	// ----------------------------------------
	// Command step table
	// ----------------------------------------
	// Returns {read, last, address, data} for step idx of an operation.
	function automatic logic [31:0] step_of(input fcs_op_t op, input logic [2:0] idx, input logic [21:0] a,
		input logic [7:0] d);
		logic [31:0] s;
		s = {1'b0, 1'b0, `FCS_ADDR_ANY, `FCS_CMD_RESET};
		if (idx == 3'h0 && op != FCS_OP_READ && op != FCS_OP_RESET && op != FCS_OP_SUSPEND
			&& op != FCS_OP_RESUME && op != FCS_OP_ADD_SECTOR) begin
			s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK1, `FCS_DATA_UNLOCK1};
		end else if (idx == 3'h1 && op != FCS_OP_READ && op != FCS_OP_RESET) begin
			s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK2, `FCS_DATA_UNLOCK2};
		end else begin
			unique case (op)
				FCS_OP_READ: s = {1'b1, 1'b1, a, 8'h00};
				FCS_OP_RESET: s = {1'b0, 1'b1, `FCS_ADDR_ANY, `FCS_CMD_RESET};
				FCS_OP_SUSPEND: s = {1'b0, 1'b1, `FCS_ADDR_ANY, `FCS_CMD_SUSPEND};
				FCS_OP_RESUME: s = {1'b0, 1'b1, `FCS_ADDR_ANY, `FCS_CMD_RESUME};
				FCS_OP_ADD_SECTOR: s = {1'b0, 1'b1, a, `FCS_CMD_SECTOR_ERASE};
				FCS_OP_PROGRAM: begin
					if (idx == 3'h2) s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK1, `FCS_CMD_PROGRAM};
					else s = {1'b0, 1'b1, a, d};
				end
				FCS_OP_AUTOSELECT: begin
					if (idx == 3'h2) s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK1, `FCS_CMD_AUTOSELECT};
					else s = {1'b1, 1'b1, a, 8'h00};
				end
				FCS_OP_CHIP_ERASE, FCS_OP_SECTOR_ERASE: begin
					unique case (idx)
						3'h2: s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK1, `FCS_CMD_ERASE_SETUP};
						3'h3: s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK1, `FCS_DATA_UNLOCK1};
						3'h4: s = {1'b0, 1'b0, `FCS_ADDR_UNLOCK2, `FCS_DATA_UNLOCK2};
						default: begin
							if (op == FCS_OP_CHIP_ERASE) s = {1'b0, 1'b1, `FCS_ADDR_UNLOCK1, `FCS_CMD_CHIP_ERASE};
							else s = {1'b0, 1'b1, a, `FCS_CMD_SECTOR_ERASE};
						end
					endcase
				end
				default: s = {1'b0, 1'b1, `FCS_ADDR_ANY, `FCS_CMD_RESET};
			endcase
		end
		return s;
	endfunction

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	fcs_state_t state;
	fcs_op_t op;
	logic [2:0] idx;
	logic [21:0] reg_addr;
	logic [7:0] reg_data;
	logic [7:0] rd_byte;
	logic [7:0] prev;
	logic hw_reset;
	logic done;
	logic fail;
	logic pend;
	logic aw_got;
	logic w_got;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic cyc_done;
	logic [7:0] cyc_rdata;

	wire [31:0] cur_step = step_of(op, idx, reg_addr, reg_data);
	wire step_read = cur_step[31];
	wire step_last = cur_step[30];
	wire busy = (state != FCS_ST_IDLE);
	wire in_poll = (state == FCS_ST_POLL_A) || (state == FCS_ST_POLL_B) || (state == FCS_ST_POLL_C)
		|| (state == FCS_ST_FINAL);
	wire cyc_read = in_poll || step_read;
	wire [21:0] cyc_addr = in_poll ? reg_addr : cur_step[29:8];
	wire cyc_start = busy && !pend;
	wire needs_poll = (op == FCS_OP_PROGRAM) || (op == FCS_OP_CHIP_ERASE) || (op == FCS_OP_SECTOR_ERASE)
		|| (op == FCS_OP_RESUME);
	wire toggled = prev[`FCS_TOGGLE_BIT] != cyc_rdata[`FCS_TOGGLE_BIT];
	wire wr_fire = aw_got && w_got && !o_s_bvalid;
	wire wr_ctrl = wr_fire && (aw_addr == `FCS_REG_CTRL) && w_data[`FCS_CTRL_START] && !busy;
	wire wr_mapped = (aw_addr == `FCS_REG_CTRL) || (aw_addr == `FCS_REG_ADDR) || (aw_addr == `FCS_REG_DATA)
		|| (aw_addr == `FCS_REG_STATUS);
	wire rd_mapped = (i_s_araddr == `FCS_REG_CTRL) || (i_s_araddr == `FCS_REG_ADDR)
		|| (i_s_araddr == `FCS_REG_DATA) || (i_s_araddr == `FCS_REG_STATUS);
	wire [31:0] status_word = {16'h0000, rd_byte, 4'h0, i_fl_ready_busy_n, fail, done, busy};
	wire [31:0] rd_word = (i_s_araddr == `FCS_REG_CTRL) ? {23'h000000, hw_reset, 4'h0, 4'(op)} :
		(i_s_araddr == `FCS_REG_ADDR) ? {10'h000, reg_addr} :
		(i_s_araddr == `FCS_REG_DATA) ? {24'h000000, reg_data} :
		(i_s_araddr == `FCS_REG_STATUS) ? status_word : 32'h00000000;

	// ----------------------------------------
	// Flash bus cycle engine
	// ----------------------------------------
	fcs_bus_cycle u_cycle (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_start(cyc_start),
		.i_read(cyc_read),
		.i_addr(cyc_addr),
		.i_wdata(cur_step[7:0]),
		.i_dq_in(i_fl_dq_in),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_addr(o_fl_addr),
		.o_dq_out(o_fl_dq_out),
		.o_dq_oe(o_fl_dq_oe),
		.o_ce_n(o_fl_ce_n),
		.o_we_n(o_fl_we_n),
		.o_oe_n(o_fl_oe_n)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// Completion is judged by the toggle bit: it serves both program and erase at
	// the register address, and also covers the protected-sector busy windows.
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= FCS_ST_IDLE;
			op <= FCS_OP_READ;
			idx <= 3'h0;
			pend <= 1'b0;
			prev <= 8'h00;
			rd_byte <= 8'h00;
			done <= 1'b0;
			fail <= 1'b0;
		end else if (i_ce) begin
			if (cyc_start) pend <= 1'b1;
			if (cyc_done) pend <= 1'b0;
			unique case (state)
				FCS_ST_IDLE: begin
					if (wr_ctrl) begin
						state <= FCS_ST_CMD;
						op <= fcs_op_t'(w_data[`FCS_CTRL_OP_MSB:`FCS_CTRL_OP_LSB]);
						idx <= 3'h0;
						done <= 1'b0;
						fail <= 1'b0;
					end
				end
				FCS_ST_CMD: begin
					if (cyc_done) begin
						idx <= idx + 3'h1;
						if (step_read) rd_byte <= cyc_rdata;
						if (step_last) begin
							state <= needs_poll ? FCS_ST_POLL_A : FCS_ST_IDLE;
							done <= !needs_poll;
						end
					end
				end
				FCS_ST_POLL_A: begin
					if (cyc_done) begin
						prev <= cyc_rdata;
						state <= FCS_ST_POLL_B;
					end
				end
				FCS_ST_POLL_B: begin
					if (cyc_done) begin
						prev <= cyc_rdata;
						if (!toggled) state <= FCS_ST_FINAL;
						else if (cyc_rdata[`FCS_TIMEOUT_BIT]) state <= FCS_ST_POLL_C;
					end
				end
				FCS_ST_POLL_C: begin
					if (cyc_done) begin
						if (!toggled) begin
							state <= FCS_ST_FINAL;
						end else begin
							fail <= 1'b1;
							op <= FCS_OP_RESET;
							idx <= 3'h0;
							state <= FCS_ST_CMD;
						end
					end
				end
				FCS_ST_FINAL: begin
					if (cyc_done) begin
						rd_byte <= cyc_rdata;
						done <= 1'b1;
						state <= FCS_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_s_awready <= 1'b1;
			o_s_wready <= 1'b1;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h00000000;
			o_s_bvalid <= 1'b0;
			o_s_bresp <= `FCS_RESP_OKAY;
			o_s_arready <= 1'b1;
			o_s_rvalid <= 1'b0;
			o_s_rdata <= 32'h00000000;
			o_s_rresp <= `FCS_RESP_OKAY;
			reg_addr <= 22'h000000;
			reg_data <= 8'h00;
			hw_reset <= 1'b0;
			o_fl_reset_n <= 1'b1;
		end else if (i_ce) begin
			o_fl_reset_n <= !hw_reset;
			if (o_s_awready && i_s_awvalid) begin
				aw_got <= 1'b1;
				aw_addr <= i_s_awaddr;
				o_s_awready <= 1'b0;
			end
			if (o_s_wready && i_s_wvalid) begin
				w_got <= 1'b1;
				w_data <= i_s_wdata;
				o_s_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				o_s_bvalid <= 1'b1;
				o_s_bresp <= wr_mapped ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
				// Address and data stay put while an operation runs; the steps read both, the poll reads the address
				if (aw_addr == `FCS_REG_CTRL) hw_reset <= w_data[`FCS_CTRL_HWRST];
				if (aw_addr == `FCS_REG_ADDR && !busy) reg_addr <= w_data[21:0];
				if (aw_addr == `FCS_REG_DATA && !busy) reg_data <= w_data[7:0];
			end
			if (o_s_bvalid && i_s_bready) begin
				o_s_bvalid <= 1'b0;
				o_s_awready <= 1'b1;
				o_s_wready <= 1'b1;
			end
			if (o_s_arready && i_s_arvalid) begin
				o_s_arready <= 1'b0;
				o_s_rvalid <= 1'b1;
				o_s_rdata <= rd_word;
				o_s_rresp <= rd_mapped ? `FCS_RESP_OKAY : `FCS_RESP_SLVERR;
			end
			if (o_s_rvalid && i_s_rready) begin
				o_s_rvalid <= 1'b0;
				o_s_arready <= 1'b1;
			end
		end
	end
endmodule

// ==== tb/fcs_ctrl_chk.sv ====
// Concurrent checks on the AXI side and the flash strobes of fcs_ctrl.
// Sees only top-level ports; bound into every fcs_ctrl instance.
`timescale 1ns/1ps
module fcs_ctrl_chk (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [3:0] i_s_awaddr,
	input wire logic i_s_awvalid,
	input wire logic o_s_awready,
	input wire logic i_s_wvalid,
	input wire logic o_s_wready,
	input wire logic [1:0] o_s_bresp,
	input wire logic o_s_bvalid,
	input wire logic i_s_bready,
	input wire logic i_s_arvalid,
	input wire logic o_s_arready,
	input wire logic o_s_rvalid,
	input wire logic i_s_rready,
	input wire logic [31:0] o_s_rdata,
	input wire logic [21:0] o_fl_addr,
	input wire logic [7:0] o_fl_dq_out,
	input wire logic o_fl_dq_oe,
	input wire logic o_fl_ce_n,
	input wire logic o_fl_we_n,
	input wire logic o_fl_oe_n
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	a_bvalid_holds: assert property (o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp))
		else $error("write response dropped early");
	a_rvalid_holds: assert property (o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid)
		else $error("read answer late");
	a_unmapped_resp: assert property (i_s_awvalid && o_s_awready && i_s_wvalid && o_s_wready
		&& i_s_awaddr[1:0] != 2'h0 |=> ##1 o_s_bvalid && o_s_bresp == 2'h2) else $error("unmapped write not refused");
	a_strobe_excl: assert property (!(!o_fl_we_n && !o_fl_oe_n))
		else $error("write and read strobes together");
	a_write_drive: assert property (!o_fl_we_n |-> !o_fl_ce_n && o_fl_dq_oe)
		else $error("write strobe without select or data drive");
	a_pulse_width: assert property ($fell(o_fl_we_n) |=> !o_fl_we_n ##1 o_fl_we_n)
		else $error("write strobe width wrong");
	a_addr_steady: assert property (!o_fl_we_n && !$past(o_fl_we_n) |-> $stable(o_fl_addr) && $stable(o_fl_dq_out))
		else $error("address or data moved under strobe");
endmodule

bind fcs_ctrl fcs_ctrl_chk fcs_ctrl_chk_i (.i_ref_clk, .i_rstn, .i_s_awaddr, .i_s_awvalid, .o_s_awready,
	.i_s_wvalid, .o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready, .i_s_arvalid, .o_s_arready, .o_s_rvalid,
	.i_s_rready, .o_s_rdata, .o_fl_addr, .o_fl_dq_out, .o_fl_dq_oe, .o_fl_ce_n, .o_fl_we_n, .o_fl_oe_n);

// ==== tb/fcs_flash_model.sv ====
// Behavioural byte-wide flash: command decode, status polling, ready/busy.
// Event driven on the strobes; busy time is counted in status reads.
`timescale 1ns/1ps
module fcs_flash_model #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
	parameter logic [3:0] PROT_GROUP = 4'hF,
	parameter int BUSY_READS = 4
) (
	input wire logic [21:0] i_addr,
	input wire logic [7:0] i_dq,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic i_reset_n,
	output logic [7:0] o_dq,
	output logic o_ready_busy_n
);
	logic [7:0] mem [logic [21:0]];
	logic [21:0] alat, pa;
	logic [7:0] pd, q, d;
	logic prog, erase, susp, asel, chip, tog;
	logic [5:0] sect;
	int step, left;
	wire wr_act = !i_ce_n && !i_we_n;
	wire rd_act = !i_ce_n && !i_oe_n;
	wire busy = prog || (erase && !susp);
	// A released bus shows the inverse, never a stale match
	assign o_dq = rd_act ? q : ~q;
	assign o_ready_busy_n = !busy;
	task automatic clr();
		{prog, erase, susp, asel, chip, tog} = 6'h00;
		step = 0;
		q = 8'h00;
	endtask
	task automatic finish_op();
		if (prog && pa[21:18] != PROT_GROUP)
			mem[pa] = (mem.exists(pa) ? mem[pa] : 8'hFF) & pd;
		else if (!prog)
			foreach (mem[k])
				if (k[21:18] != PROT_GROUP && (chip || k[21:16] == sect))
					mem[k] = 8'hFF;
		if (prog)
			prog = 1'b0;
		else
			erase = 1'b0;
	endtask
	initial clr();
	always @(negedge i_reset_n) clr();
	always @(posedge wr_act) alat = i_addr;
	always @(negedge wr_act) begin
		d = i_dq;
		if (busy) begin
			if (erase && !chip && d == 8'hB0)
				susp = 1'b1;
		end else if (d == 8'hF0) begin
			step = 0;
			asel = 1'b0;
		end else if (susp && step == 0 && d == 8'h30)
			susp = 1'b0;
		else case (step)
			0, 3: step = (alat[10:0] == 11'h555 && d == 8'hAA) ? step + 1 : 0;
			1, 4: step = (alat[10:0] == 11'h2AA && d == 8'h55) ? step + 1 : 0;
			2: begin
				asel = alat[10:0] == 11'h555 && d == 8'h90;
				step = alat[10:0] != 11'h555 ? 0 : d == 8'hA0 ? 6 : (d == 8'h80 && !susp) ? 3 : 0;
			end
			5: begin
				step = 0;
				chip = alat[10:0] == 11'h555 && d == 8'h10;
				erase = chip || d == 8'h30;
				sect = alat[21:16];
				left = BUSY_READS * 4;
			end
			default: begin
				step = 0;
				prog = 1'b1;
				pa = alat;
				pd = d;
				left = BUSY_READS;
			end
		endcase
	end
	always @(posedge rd_act) begin
		if (busy) begin
			tog = !tog;
			q = {prog ? ~pd[7] : 1'b0, tog, 6'h00};
			left = left - 1;
			if (left == 0)
				finish_op();
		end else if (asel)
			q = i_addr[7:0] == 8'h00 ? MAKER_CODE : i_addr[7:0] == 8'h01 ? PART_CODE
				: {7'h00, i_addr[21:18] == PROT_GROUP};
		else if (susp && i_addr[21:16] == sect)
			q = {1'b1, tog, 6'h00};
		else
			q = mem.exists(i_addr) ? mem[i_addr] : 8'hFF;
	end
endmodule

// ==== tb/test_flash_command_status_unit.sv ====
// Self-checking bench: AXI4-Lite master tasks, behavioural flash on the pins.
// Expected program and read bytes come from a bench-side copy of the array; erase, protection and autoselect checks use fixed bytes.
`timescale 1ns/1ps
`include "fcs_defs.svh"
module test_flash_command_status_unit;
	import fcs_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, seed = 32'h0001259A;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, dq_oe, ce_n, we_n, oe_n, fl_rst_n, rb_n;
	logic [1:0] bresp, rresp;
	logic [21:0] fl_addr;
	logic [7:0] dq_out, dq_in;
	logic [7:0] ref_mem [logic [21:0]];
	logic [21:0] done_q[$];
	int fail_count = 0, checked = 0, cyc = 0;
	fcs_ctrl fcs_ctrl_i (.i_ref_clk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_s_awaddr(awaddr), .i_s_awvalid(awvalid),
		.o_s_awready(awready), .i_s_wdata(wdata), .i_s_wstrb(4'hF), .i_s_wvalid(wvalid), .o_s_wready(wready),
		.o_s_bresp(bresp), .o_s_bvalid(bvalid), .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
		.o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp), .o_s_rvalid(rvalid), .i_s_rready(rready),
		.o_fl_addr(fl_addr), .o_fl_dq_out(dq_out), .o_fl_dq_oe(dq_oe), .i_fl_dq_in(dq_in), .o_fl_ce_n(ce_n),
		.o_fl_we_n(we_n), .o_fl_oe_n(oe_n), .o_fl_reset_n(fl_rst_n), .i_fl_ready_busy_n(rb_n));
	fcs_flash_model fcs_flash_model_i (.i_addr(fl_addr), .i_dq(dq_out), .i_ce_n(ce_n), .i_we_n(we_n),
		.i_oe_n(oe_n), .i_reset_n(fl_rst_n), .o_dq(dq_in), .o_ready_busy_n(rb_n));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			conclude();
		end
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] arr(input logic [21:0] k);
		return ref_mem.exists(k) ? ref_mem[k] : 8'hFF;
	endfunction
	task automatic conclude();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		cmp_val(nm, {30'h0, e}, {30'h0, g});
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic got;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				got = 1'b1;
				bready <= 1'b0;
				cmp_resp("bresp", er, bresp);
			end
		end
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		got = 1'b0;
		while (!got) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				got = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask
	// Start an operation and poll STATUS until done; returns the last read byte
	task automatic run_op(input fcs_op_t op, input logic [21:0] a, input logic [7:0] d, output logic [7:0] rb);
		logic [31:0] st;
		logic [1:0] r;
		axi_wr(`FCS_REG_ADDR, {10'h000, a}, `FCS_RESP_OKAY);
		axi_wr(`FCS_REG_DATA, {24'h000000, d}, `FCS_RESP_OKAY);
		axi_wr(`FCS_REG_CTRL, {27'h0000000, 1'b1, op}, `FCS_RESP_OKAY);
		st = 32'h0;
		for (int n = 0; n < 400 && st[1] !== 1'b1; n++)
			axi_rd(`FCS_REG_STATUS, st, r);
		cmp_val("done bit", 32'h1, {31'h0, st[1]});
		cmp_val("fail bit", 32'h0, {31'h0, st[2]});
		rb = st[15:8];
	endtask
	initial begin
		logic [31:0] st;
		logic [21:0] a;
		logic [7:0] d, rb;
		logic [1:0] r;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		axi_rd(`FCS_REG_STATUS, st, r);
		cmp_val("idle status", 32'h8, {28'h0, st[3:0]});
		axi_wr(4'h6, 32'h0, `FCS_RESP_SLVERR);
		axi_rd(4'h6, st, r);
		cmp_resp("rresp", `FCS_RESP_SLVERR, r);
		for (int i = 0; i < 6; i++) begin
			st = rnd();
			a = i == 0 ? 22'h000555 : {1'b0, st[20:0]};
			d = i == 0 ? 8'h00 : st[31:24];
			ref_mem[a] = arr(a) & d;
			done_q.push_back(a);
			run_op(FCS_OP_PROGRAM, a, d, rb);
			cmp_val("program readback", {24'h0, arr(a)}, {24'h0, rb});
			run_op(FCS_OP_READ, a, 8'h00, rb);
			cmp_val("array read", {24'h0, arr(a)}, {24'h0, rb});
		end
		run_op(FCS_OP_PROGRAM, 22'h3C0123, 8'h00, rb);
		run_op(FCS_OP_READ, 22'h3C0123, 8'h00, rb);
		cmp_val("protected program", 32'hFF, {24'h0, rb});
		for (int k = 0; k < 4; k++) begin
			run_op(FCS_OP_AUTOSELECT, {k == 2 ? 4'hF : 4'h1, 16'h0000, k == 3 ? 2'h2 : 2'(k)}, 8'h00, rb);
			d = k == 0 ? 8'h5A : k == 1 ? 8'hC3 : k == 2 ? 8'h01 : 8'h00;
			cmp_val("autoselect", {24'h0, d}, {24'h0, rb});
		end
		run_op(FCS_OP_RESET, 22'h000000, 8'h00, rb);
		run_op(FCS_OP_READ, done_q[1], 8'h00, rb);
		cmp_val("read after reset", {24'h0, arr(done_q[1])}, {24'h0, rb});
		run_op(FCS_OP_SECTOR_ERASE, a, 8'h00, rb);
		run_op(FCS_OP_READ, a, 8'h00, rb);
		cmp_val("sector erased", 32'hFF, {24'h0, rb});
		run_op(FCS_OP_CHIP_ERASE, 22'h000000, 8'h00, rb);
		foreach (done_q[j]) begin
			run_op(FCS_OP_READ, done_q[j], 8'h00, rb);
			cmp_val("chip erased", 32'hFF, {24'h0, rb});
		end
		axi_wr(`FCS_REG_CTRL, 32'h00000100, `FCS_RESP_OKAY);
		repeat (3) @(posedge clk);
		cmp_val("flash reset pin", 32'h0, {31'h0, fl_rst_n});
		axi_wr(`FCS_REG_CTRL, 32'h00000000, `FCS_RESP_OKAY);
		repeat (3) @(posedge clk);
		cmp_val("flash reset pin", 32'h1, {31'h0, fl_rst_n});
		conclude();
	end
endmodule
